// ---- include/wlsd_pkg.sv ----
// Package for the wide load/store decoder: field positions, group
// patterns and the decoded-operation carrier.
// Assumes a 32-bit instruction with the first halfword in bits 31:16.
package wlsd_pkg;

  // ***************************************************
  // Field positions
  // ***************************************************
  localparam int GRP_HI = 31;
  localparam int LS_GRP_LO = 25;
  localparam int LSM_MID_LO = 22;
  localparam int DX_MID_BIT = 22;
  localparam int LD_GRP_LO = 25;
  localparam int MAJ_HI = 24;
  localparam int MAJ_LO = 23;
  localparam int LFLAG_BIT = 20;
  localparam int WB_BIT = 21;
  localparam int MIN2_HI = 21;
  localparam int MIN2_LO = 20;
  localparam int BASE_HI = 19;
  localparam int BASE_LO = 16;
  localparam int XFER_HI = 15;
  localparam int XFER_LO = 12;
  localparam int MIN6_HI = 11;
  localparam int MIN6_LO = 6;
  localparam int SUB_HI = 7;
  localparam int SUB_LO = 4;
  localparam int LD_SUB_HI = 22;
  localparam int LD_SUB_LO = 20;

  // ***************************************************
  // Group patterns
  // ***************************************************
  localparam logic [6:0] LS_GRP_PAT = 7'h74;
  localparam logic [6:0] LD_GRP_PAT = 7'h7C;
  localparam logic [2:0] WORD_SUB = 3'h5;
  localparam logic [2:0] HALF_SUB = 3'h3;
  localparam logic [3:0] PC_REG = 4'hF;
  localparam logic [4:0] STACK_WB_BASE = 5'h1D;
  localparam logic [3:0] SUB_BYTE_TBL = 4'h0;
  localparam logic [3:0] SUB_HALF_TBL = 4'h1;
  localparam logic [3:0] SUB_EX_BYTE = 4'h4;
  localparam logic [3:0] SUB_EX_HALF = 4'h5;

  // ***************************************************
  // Operation classes
  // ***************************************************
  typedef enum logic [4:0] {
    OP_NONE = 5'h00,
    OP_STORE_MULTIPLE_INC_AFTER = 5'h01,
    OP_LOAD_MULTIPLE_INC_AFTER = 5'h02,
    OP_STACK_RESTORE = 5'h03,
    OP_STORE_MULTIPLE_DEC_BEFORE = 5'h04,
    OP_STACK_SAVE = 5'h05,
    OP_LOAD_MULTIPLE_DEC_BEFORE = 5'h06,
    OP_EXCLUSIVE_WORD_STORE = 5'h07,
    OP_EXCLUSIVE_WORD_LOAD = 5'h08,
    OP_EXCLUSIVE_BYTE_STORE = 5'h09,
    OP_EXCLUSIVE_HALF_STORE = 5'h0A,
    OP_EXCLUSIVE_BYTE_LOAD = 5'h0B,
    OP_EXCLUSIVE_HALF_LOAD = 5'h0C,
    OP_PAIRED_REGISTER_STORE = 5'h0D,
    OP_PAIRED_REGISTER_LOAD = 5'h0E,
    OP_BYTE_TABLE_BRANCH = 5'h0F,
    OP_HALF_TABLE_BRANCH = 5'h10,
    OP_WORD_LOAD = 5'h11,
    OP_UNSIGNED_HALF_LOAD = 5'h12,
    OP_SIGNED_HALF_LOAD = 5'h13
  } wlsd_op_t;

  typedef enum logic [1:0] {
    AM_NONE = 2'h0,
    AM_IMMEDIATE = 2'h1,
    AM_REGISTER = 2'h2,
    AM_LITERAL = 2'h3
  } wlsd_addr_t;

  typedef struct packed {
    wlsd_op_t op;
    wlsd_addr_t addr;
    logic unpriv;
    logic nop;
    logic undef;
    logic unpred;
    logic mem_en;
    logic wb_en;
  } wlsd_dec_t;

  localparam wlsd_dec_t DEC_RESET = '{OP_NONE, AM_NONE, 1'b0, 1'b0,
                                      1'b0, 1'b0, 1'b0, 1'b0};

endpackage : wlsd_pkg

// ---- rtl/wlsd_decoder.sv ----
// Decoder for the wide load/store, dual/exclusive and load word and
// halfword groups; result registered into the execute stage.
// Assumes the fetch stage presents a whole 32-bit word each cycle.
//
// Overview of operation
// - Opcode 01, load 0: store multiple, increment after.
// - Opcode 01, load 1, writeback-plus-base not 11101: load multiple increment after.
// - Opcode 01, load 1, writeback-plus-base 11101: stack restore.
// - Opcode 10, load 0, not 11101: store multiple decrement before.
// - Opcode 10, load 0, writeback-plus-base 11101: stack save.
// - Opcode 10, load 1: load multiple decrement before, any base.
// - Unallocated combinations in each group are flagged undefined.
// - Dual group store-exclusive word, byte and halfword encodings.
// - Dual group load-exclusive word, byte and halfword encodings.
// - Major 0x minor 10, or 1x minor x0: paired store.
// - Major 0x minor 11, or 1x minor x1: paired load.
// - Major 01 minor 01: byte table branch 0000, half 0001.
// - Word group, base not PC: immediate-offset word load forms.
// - Word group, major 00 minor 000000: register-offset word load.
// - Word group, base PC, major 0x: literal word load.
// - Word and half groups, minor 1110xx: unprivileged load.
// - Half group, base PC, transfer not PC: literal load by sign.
// - Half group: unsigned immediate and register-offset loads.
// - Half group: signed immediate, register and unprivileged loads.
// - Half group, transfer PC: listed cases are no-operation hints.
// - Half group, transfer PC, minor 1xx1xx or 1110xx: unpredictable.
`timescale 1ns/10ps
module wlsd_decoder (
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic INSTR_VALID_I,
  input wire logic [31:0] INSTR_I,
  output wlsd_pkg::wlsd_dec_t DEC_O,
  output logic DEC_VALID_O,
  output logic UNDEF_EXC_REQ_O
);

  // ***************************************************
  // Fields
  // ***************************************************
  logic [1:0] maj;
  logic [1:0] min2;
  logic [5:0] min6;
  logic [3:0] sub;
  logic [3:0] base;
  logic [3:0] xfer;
  logic [4:0] wb_base;
  logic grp_lsm;
  logic grp_dx;
  logic grp_word;
  logic grp_half;
  logic base_pc;
  logic xfer_pc;
  logic m_imm;
  logic m_reg;
  logic m_unp;
  logic m_hint;
  wlsd_pkg::wlsd_dec_t dec;

  assign maj = INSTR_I[wlsd_pkg::MAJ_HI:wlsd_pkg::MAJ_LO];
  assign min2 = INSTR_I[wlsd_pkg::MIN2_HI:wlsd_pkg::MIN2_LO];
  assign min6 = INSTR_I[wlsd_pkg::MIN6_HI:wlsd_pkg::MIN6_LO];
  assign sub = INSTR_I[wlsd_pkg::SUB_HI:wlsd_pkg::SUB_LO];
  assign base = INSTR_I[wlsd_pkg::BASE_HI:wlsd_pkg::BASE_LO];
  assign xfer = INSTR_I[wlsd_pkg::XFER_HI:wlsd_pkg::XFER_LO];
  // Writeback bit joined to base; the load flag sits between them
  assign wb_base = {INSTR_I[wlsd_pkg::WB_BIT], base};
  assign base_pc = (base == wlsd_pkg::PC_REG);
  assign xfer_pc = (xfer == wlsd_pkg::PC_REG);
  // Shared group prefix; bit 22 splits multiple from dual/exclusive
  assign grp_lsm = (INSTR_I[wlsd_pkg::GRP_HI:wlsd_pkg::LS_GRP_LO]
                    == wlsd_pkg::LS_GRP_PAT)
                   && !INSTR_I[wlsd_pkg::DX_MID_BIT];
  assign grp_dx = (INSTR_I[wlsd_pkg::GRP_HI:wlsd_pkg::LS_GRP_LO]
                   == wlsd_pkg::LS_GRP_PAT)
                  && INSTR_I[wlsd_pkg::DX_MID_BIT];
  assign grp_word = (INSTR_I[wlsd_pkg::GRP_HI:wlsd_pkg::LD_GRP_LO]
                     == wlsd_pkg::LD_GRP_PAT)
                    && (INSTR_I[wlsd_pkg::LD_SUB_HI:wlsd_pkg::LD_SUB_LO]
                        == wlsd_pkg::WORD_SUB);
  assign grp_half = (INSTR_I[wlsd_pkg::GRP_HI:wlsd_pkg::LD_GRP_LO]
                     == wlsd_pkg::LD_GRP_PAT)
                    && (INSTR_I[wlsd_pkg::LD_SUB_HI:wlsd_pkg::LD_SUB_LO]
                        == wlsd_pkg::HALF_SUB);
  // Minor opcode classes shared by word and half groups
  assign m_imm = (min6[5] && min6[2]) || (min6[5:2] == 4'hC);
  assign m_reg = (min6 == 6'h00);
  assign m_unp = (min6[5:2] == 4'hE);
  assign m_hint = m_reg || (min6[5:2] == 4'hC);

  // ***************************************************
  // Combinational decode
  // ***************************************************
  always_comb begin
    dec = wlsd_pkg::DEC_RESET;
    dec.undef = 1'b1;
    if (grp_lsm) begin
      unique case (maj)
        2'b01: begin
          dec.undef = 1'b0;
          if (!INSTR_I[wlsd_pkg::LFLAG_BIT]) begin
            dec.op = wlsd_pkg::OP_STORE_MULTIPLE_INC_AFTER;
          end else if (wb_base != wlsd_pkg::STACK_WB_BASE) begin
            dec.op = wlsd_pkg::OP_LOAD_MULTIPLE_INC_AFTER;
          end else begin
            dec.op = wlsd_pkg::OP_STACK_RESTORE;
          end
        end
        2'b10: begin
          dec.undef = 1'b0;
          if (INSTR_I[wlsd_pkg::LFLAG_BIT]) begin
            dec.op = wlsd_pkg::OP_LOAD_MULTIPLE_DEC_BEFORE;
          end else if (wb_base != wlsd_pkg::STACK_WB_BASE) begin
            dec.op = wlsd_pkg::OP_STORE_MULTIPLE_DEC_BEFORE;
          end else begin
            dec.op = wlsd_pkg::OP_STACK_SAVE;
          end
        end
        default: dec.undef = 1'b1;
      endcase
    end else if (grp_dx) begin
      dec.undef = 1'b0;
      if ((!maj[1] && min2 == 2'b10) || (maj[1] && !min2[0])) begin
        dec.op = wlsd_pkg::OP_PAIRED_REGISTER_STORE;
        dec.addr = wlsd_pkg::AM_IMMEDIATE;
      end else if ((!maj[1] && min2 == 2'b11) || (maj[1] && min2[0])) begin
        dec.op = wlsd_pkg::OP_PAIRED_REGISTER_LOAD;
        dec.addr = base_pc ? wlsd_pkg::AM_LITERAL : wlsd_pkg::AM_IMMEDIATE;
      end else if (maj == 2'b00) begin
        dec.op = min2[0] ? wlsd_pkg::OP_EXCLUSIVE_WORD_LOAD
                         : wlsd_pkg::OP_EXCLUSIVE_WORD_STORE;
        dec.addr = wlsd_pkg::AM_IMMEDIATE;
      end else if (!min2[0] && sub == wlsd_pkg::SUB_EX_BYTE) begin
        dec.op = wlsd_pkg::OP_EXCLUSIVE_BYTE_STORE;
      end else if (!min2[0] && sub == wlsd_pkg::SUB_EX_HALF) begin
        dec.op = wlsd_pkg::OP_EXCLUSIVE_HALF_STORE;
      end else if (min2[0] && sub == wlsd_pkg::SUB_EX_BYTE) begin
        dec.op = wlsd_pkg::OP_EXCLUSIVE_BYTE_LOAD;
      end else if (min2[0] && sub == wlsd_pkg::SUB_EX_HALF) begin
        dec.op = wlsd_pkg::OP_EXCLUSIVE_HALF_LOAD;
      end else if (min2[0] && sub == wlsd_pkg::SUB_BYTE_TBL) begin
        dec.op = wlsd_pkg::OP_BYTE_TABLE_BRANCH;
        dec.addr = wlsd_pkg::AM_REGISTER;
      end else if (min2[0] && sub == wlsd_pkg::SUB_HALF_TBL) begin
        dec.op = wlsd_pkg::OP_HALF_TABLE_BRANCH;
        dec.addr = wlsd_pkg::AM_REGISTER;
      end else begin
        dec.undef = 1'b1;
      end
    end else if (grp_word) begin
      dec.op = wlsd_pkg::OP_WORD_LOAD;
      if (base_pc && !maj[1]) begin
        dec.undef = 1'b0;
        dec.addr = wlsd_pkg::AM_LITERAL;
      end else if (!base_pc && maj == 2'b01) begin
        dec.undef = 1'b0;
        dec.addr = wlsd_pkg::AM_IMMEDIATE;
      end else if (!base_pc && maj == 2'b00) begin
        dec.undef = !(m_imm || m_reg || m_unp);
        dec.addr = m_reg ? wlsd_pkg::AM_REGISTER
                         : wlsd_pkg::AM_IMMEDIATE;
        dec.unpriv = m_unp;
      end else begin
        dec.op = wlsd_pkg::OP_NONE;
      end
    end else if (grp_half) begin
      dec.undef = 1'b0;
      if (xfer_pc) begin
        // Hints keep no side effect; unpredictable forms are trapped
        if (base_pc || maj[0] || m_hint) begin
          dec.nop = 1'b1;
        end else if (m_imm || m_unp) begin
          dec.unpred = 1'b1;
          dec.undef = 1'b1;
        end else begin
          dec.undef = 1'b1;
        end
      end else begin
        dec.op = maj[1] ? wlsd_pkg::OP_SIGNED_HALF_LOAD
                        : wlsd_pkg::OP_UNSIGNED_HALF_LOAD;
        if (base_pc) begin
          dec.addr = wlsd_pkg::AM_LITERAL;
        end else if (maj[0] || m_imm) begin
          dec.addr = wlsd_pkg::AM_IMMEDIATE;
        end else if (m_reg) begin
          dec.addr = wlsd_pkg::AM_REGISTER;
        end else if (m_unp) begin
          dec.addr = wlsd_pkg::AM_IMMEDIATE;
          dec.unpriv = 1'b1;
        end else begin
          dec.op = wlsd_pkg::OP_NONE;
          dec.undef = 1'b1;
        end
      end
    end
    // No access and no writeback for undefined or hint forms
    if (dec.undef) begin
      dec.op = wlsd_pkg::OP_NONE;
      dec.addr = wlsd_pkg::AM_NONE;
      dec.unpriv = 1'b0;
    end
    dec.mem_en = !dec.undef && !dec.nop
                 && dec.op != wlsd_pkg::OP_NONE;
    dec.wb_en = dec.mem_en
                && dec.op != wlsd_pkg::OP_PAIRED_REGISTER_STORE
                && dec.op != wlsd_pkg::OP_EXCLUSIVE_WORD_STORE
                && dec.op != wlsd_pkg::OP_EXCLUSIVE_BYTE_STORE
                && dec.op != wlsd_pkg::OP_EXCLUSIVE_HALF_STORE
                && dec.op != wlsd_pkg::OP_BYTE_TABLE_BRANCH
                && dec.op != wlsd_pkg::OP_HALF_TABLE_BRANCH
                && dec.op != wlsd_pkg::OP_STORE_MULTIPLE_INC_AFTER
                && dec.op != wlsd_pkg::OP_STORE_MULTIPLE_DEC_BEFORE
                && dec.op != wlsd_pkg::OP_STACK_SAVE;
  end

  // ***************************************************
  // Pipeline register
  // ***************************************************
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      DEC_O <= wlsd_pkg::DEC_RESET;
      DEC_VALID_O <= 1'b0;
      UNDEF_EXC_REQ_O <= 1'b0;
    end else begin
      DEC_O <= INSTR_VALID_I ? dec : wlsd_pkg::DEC_RESET;
      DEC_VALID_O <= INSTR_VALID_I;
      UNDEF_EXC_REQ_O <= INSTR_VALID_I && dec.undef;
    end
  end

endmodule : wlsd_decoder

// ---- verif/tb.sv ----
// Self-checking bench for the decoder against a reference model.
// Assumes the decoder answers on the rising edge after each input is driven.
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
  $display("mismatch %s exp %0h got %0h", n, e, g); end end
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic vld = 1'b0;
  logic [31:0] ins = 32'h0;
  logic [31:0] seed = 32'h1B5A2F03;
  logic [31:0] pins, x;
  logic pval = 1'b0;
  wlsd_pkg::wlsd_dec_t dec, e;
  logic dvld, exc;
  bit ca;
  int errors = 0;
  int checks = 0;
  int exc_cnt = 0;
  int exc_seen;
  always #50 clk = ~clk;
  wlsd_decoder DUT (.CORE_CLK_I(clk), .RST_N_I(rst_n), .INSTR_VALID_I(vld),
    .INSTR_I(ins), .DEC_O(dec), .DEC_VALID_O(dvld), .UNDEF_EXC_REQ_O(exc));
  wlsd_exec_model u_exec (.clk_i(clk), .rst_n_i(rst_n), .dec_valid_i(dvld),
    .exc_req_i(exc), .exc_o(exc_seen));
  // ****************
  // Reference model
  // ****************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
  endfunction : lfsr
  function automatic wlsd_pkg::wlsd_dec_t ref_dec(input logic [31:0] i,
      output bit c);
    wlsd_pkg::wlsd_dec_t d;
    wlsd_pkg::wlsd_addr_t f;
    logic [1:0] mj, mn;
    logic [5:0] m6;
    logic bp, tp, im, ld, stk;
    d = wlsd_pkg::DEC_RESET;
    c = 0;
    ld = 1;
    f = wlsd_pkg::AM_NONE;
    mj = i[24:23];
    mn = i[21:20];
    m6 = i[11:6];
    bp = i[19:16] == 4'hF;
    tp = i[15:12] == 4'hF;
    stk = {i[21], i[19:16]} == 5'h1D;
    im = mj[0] | (m6[5] & m6[2]) | (m6[5:2] == 4'hC) | (m6[5:2] == 4'hE);
    if (i[31:25] == 7'h74 && !i[22]) begin
      ld = i[20];
      case ({mj, ld})
        3'h2: d.op = wlsd_pkg::OP_STORE_MULTIPLE_INC_AFTER;
        3'h3: d.op = stk ? wlsd_pkg::OP_STACK_RESTORE :
          wlsd_pkg::OP_LOAD_MULTIPLE_INC_AFTER;
        3'h4: d.op = stk ? wlsd_pkg::OP_STACK_SAVE :
          wlsd_pkg::OP_STORE_MULTIPLE_DEC_BEFORE;
        3'h5: d.op = wlsd_pkg::OP_LOAD_MULTIPLE_DEC_BEFORE;
        default: ;
      endcase
    end else if (i[31:25] == 7'h74) begin
      ld = mn[0] & (mj != 2'h1 | mn[1] | i[6]);
      if (mj[1] | mn[1]) begin
        d.op = ld ? wlsd_pkg::OP_PAIRED_REGISTER_LOAD :
          wlsd_pkg::OP_PAIRED_REGISTER_STORE;
        c = ld;
        f = bp ? wlsd_pkg::AM_LITERAL : wlsd_pkg::AM_IMMEDIATE;
      end else if (!mj[0]) begin
        d.op = ld ? wlsd_pkg::OP_EXCLUSIVE_WORD_LOAD :
          wlsd_pkg::OP_EXCLUSIVE_WORD_STORE;
      end else begin
        case ({mn[0], i[7:4]})
          5'h04: d.op = wlsd_pkg::OP_EXCLUSIVE_BYTE_STORE;
          5'h05: d.op = wlsd_pkg::OP_EXCLUSIVE_HALF_STORE;
          5'h10: d.op = wlsd_pkg::OP_BYTE_TABLE_BRANCH;
          5'h11: d.op = wlsd_pkg::OP_HALF_TABLE_BRANCH;
          5'h14: d.op = wlsd_pkg::OP_EXCLUSIVE_BYTE_LOAD;
          5'h15: d.op = wlsd_pkg::OP_EXCLUSIVE_HALF_LOAD;
          default: ;
        endcase
      end
    end else if (i[31:25] == 7'h7C && i[22:20] inside {3'h5, 3'h3}) begin
      if (!i[21] || !tp) begin
        f = bp ? wlsd_pkg::AM_LITERAL : im ? wlsd_pkg::AM_IMMEDIATE :
          m6 == 6'h0 ? wlsd_pkg::AM_REGISTER : wlsd_pkg::AM_NONE;
        if (!i[21] && mj[1]) f = wlsd_pkg::AM_NONE;
        c = 1;
        d.unpriv = !bp && !mj[0] && m6[5:2] == 4'hE;
        if (f != wlsd_pkg::AM_NONE) d.op = !i[21] ? wlsd_pkg::OP_WORD_LOAD :
          mj[1] ? wlsd_pkg::OP_SIGNED_HALF_LOAD : wlsd_pkg::OP_UNSIGNED_HALF_LOAD;
      end else if (bp | mj[0] | m6 == 6'h0 | m6[5:2] == 4'hC) begin
        d.nop = 1;
      end else begin
        d.unpred = (m6[5] & m6[2]) | (m6[5:2] == 4'hE);
      end
    end
    d.undef = d.op == wlsd_pkg::OP_NONE && !d.nop;
    if (d.op != wlsd_pkg::OP_NONE) d.addr = f;
    d.wb_en = ld && d.op != wlsd_pkg::OP_NONE;
    if (d.op == wlsd_pkg::OP_NONE) d.unpriv = 0;
    return d;
  endfunction : ref_dec
  // ****************
  // Checks and run
  // ****************
  task automatic check_prev();
    `CHK("valid", pval, dvld)
    if (!pval) `CHK("idle", wlsd_pkg::DEC_RESET, dec)
    if (pval) begin
      e = ref_dec(pins, ca);
      exc_cnt += e.undef;
      `CHK("op", e.op, dec.op)
      `CHK("undef", e.undef, dec.undef)
      `CHK("exc", e.undef, exc)
      `CHK("unpred", e.unpred, dec.unpred)
      `CHK("wb", e.wb_en, dec.wb_en)
      if (ca) `CHK("addr", e.addr, dec.addr)
      if (ca) `CHK("unpriv", e.unpriv, dec.unpriv)
      if (!e.unpred) `CHK("nop", e.nop, dec.nop)
      if (e.undef | e.nop) `CHK("mem", 1'b0, dec.mem_en)
    end
  endtask : check_prev
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (12) @(negedge clk);
    `CHK("reset", wlsd_pkg::DEC_RESET, dec)
    rst_n = 1'b1;
    for (int n = 0; n < 6000; n++) begin
      @(negedge clk);
      check_prev();
      seed = lfsr(seed);
      x = lfsr(seed);
      ins = {(seed[4:2] inside {3'h2, 3'h3, 3'h4}) ? 7'h7C : 7'h74, x[24:0]};
      case (seed[4:2])
        3'h0: ins[22] = 1'b0;
        3'h1: ins[22] = 1'b1;
        3'h2: ins[22:20] = 3'h5;
        3'h3: ins[22:20] = 3'h3;
        3'h4: ins[22:20] = 3'h1;
        3'h5: ins = x;
        default: {ins[22:16]} = {2'h1, seed[6], 4'hD};
      endcase
      if (seed[0]) ins[19:16] = 4'hF;
      if (seed[1]) ins[15:12] = 4'hF;
      if (seed[5] && ins[22]) {ins[7], ins[5]} = 2'h0;
      vld = seed[9:8] != 2'h0;
      if (n == 3000) begin
        rst_n = 1'b0;
        vld = 1'b0;
        exc_cnt = 0;
        @(negedge clk);
        `CHK("mid reset", wlsd_pkg::DEC_RESET, dec)
        rst_n = 1'b1;
      end
      pins = ins;
      pval = vld;
    end
    @(negedge clk);
    check_prev();
    // Sink counts one edge after the decoder result appears
    @(negedge clk);
    `CHK("exc count", exc_cnt, exc_seen)
    print_verdict();
  end
endmodule : tb

// ---- verif/wlsd_asserts.sv ----
// Checker for the wide load/store decoder ports.
// Assumes one core clock and the active-low pipeline reset.
`timescale 1ns/10ps
module wlsd_asserts (
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic INSTR_VALID_I,
  input wire logic [31:0] INSTR_I,
  input wlsd_pkg::wlsd_dec_t DEC_O,
  input wire logic DEC_VALID_O,
  input wire logic UNDEF_EXC_REQ_O
);
  logic ml, dl, wd, hf, bf, tf;
  assign ml = INSTR_VALID_I && INSTR_I[31:25] == 7'h74 && !INSTR_I[22];
  assign dl = INSTR_VALID_I && INSTR_I[31:25] == 7'h74 && INSTR_I[22];
  assign wd = INSTR_VALID_I && INSTR_I[31:25] == 7'h7C && INSTR_I[22:20] == 3'h5;
  assign hf = INSTR_VALID_I && INSTR_I[31:25] == 7'h7C && INSTR_I[22:20] == 3'h3;
  assign bf = INSTR_I[19:16] == 4'hF;
  assign tf = INSTR_I[15:12] == 4'hF;
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!RST_N_I);
  // ****************
  // Properties
  // ****************
  AST_VALID_FOLLOWS: assert property (DEC_VALID_O == $past(INSTR_VALID_I))
    else $error("valid out does not follow valid in");
  AST_IDLE_CLEAR: assert property (!DEC_VALID_O |-> DEC_O == wlsd_pkg::DEC_RESET)
    else $error("result not cleared when idle");
  AST_EXC_PULSE: assert property (UNDEF_EXC_REQ_O == (DEC_VALID_O && DEC_O.undef))
    else $error("exception request wrong");
  AST_UNDEF_QUIET: assert property (DEC_O.undef |-> !DEC_O.mem_en && !DEC_O.wb_en)
    else $error("undefined op still accesses");
  AST_STACK_RESTORE: assert property (ml && INSTR_I[24:16] == 9'h0BD |=> DEC_O.op == wlsd_pkg::OP_STACK_RESTORE)
    else $error("stack restore missed");
  AST_STACK_SAVE: assert property (ml && INSTR_I[24:16] == 9'h12D |=> DEC_O.op == wlsd_pkg::OP_STACK_SAVE)
    else $error("stack save missed");
  AST_LOAD_DEC: assert property (ml && INSTR_I[24:23] == 2'h2 && INSTR_I[20] |=> DEC_O.op == wlsd_pkg::OP_LOAD_MULTIPLE_DEC_BEFORE)
    else $error("decrement-before load missed");
  AST_PAIRED_LOAD: assert property (dl && INSTR_I[24] && INSTR_I[20] |=> DEC_O.op == wlsd_pkg::OP_PAIRED_REGISTER_LOAD)
    else $error("paired load missed");
  AST_WORD_LIT: assert property (wd && bf && !INSTR_I[24] |=> DEC_O.op == wlsd_pkg::OP_WORD_LOAD && DEC_O.addr == wlsd_pkg::AM_LITERAL)
    else $error("literal word load missed");
  AST_HINT: assert property (hf && tf && bf |=> DEC_O.nop && !DEC_O.undef && !DEC_O.mem_en)
    else $error("memory hint not a nop");
  AST_UNPRED_TRAP: assert property (DEC_O.unpred |-> UNDEF_EXC_REQ_O)
    else $error("unpredictable hint not trapped");
endmodule : wlsd_asserts
bind wlsd_decoder wlsd_asserts u_chk (.CORE_CLK_I(CORE_CLK_I),
  .RST_N_I(RST_N_I), .INSTR_VALID_I(INSTR_VALID_I), .INSTR_I(INSTR_I),
  .DEC_O(DEC_O), .DEC_VALID_O(DEC_VALID_O), .UNDEF_EXC_REQ_O(UNDEF_EXC_REQ_O));

// ---- verif/wlsd_exec_model.sv ----
// Execute-stage sink that takes the decoder's results.
// Assumes results arrive registered, one per core clock.
`timescale 1ns/10ps
module wlsd_exec_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic dec_valid_i,
  input wire logic exc_req_i,
  output int exc_o
);
  // ****************
  // Trap counting
  // ****************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      exc_o <= 0;
    end else if (dec_valid_i && exc_req_i) begin
      exc_o <= exc_o + 1;
    end
  end
endmodule : wlsd_exec_model
